// *** cptc_pkg.sv ***
// Package with register map, field positions and timing for protect config.
package cptc_pkg;

    localparam logic [7:0] PROTECT_DEBUG_CTL_ADDR = 8'hC0;
    localparam logic [7:0] PROTECT_CONFIG_ADDR    = 8'hC2;

    // Debug control field positions.
    localparam int DBG_TIMEOUT_DIS_BIT = 6;
    localparam int DBG_SYNC_DIS_BIT    = 4;
    localparam int DBG_CHKSUM_EN_BIT   = 3;
    localparam int DBG_FC_TEST_BIT     = 2;
    localparam int DBG_SPEEDUP_BIT     = 1;
    localparam int DBG_FAST_BIT        = 0;
    localparam logic [7:0] DBG_WRITE_MASK = 8'h5F;
    localparam logic [7:0] DBG_RESET      = 8'h00;

    // Configuration field positions.
    localparam int CFG_ENHANCED_VERIFY_ENABLE_BIT   = 7;
    localparam int CFG_ENHANCED_STATUS_SIGNALING_BIT     = 6;
    localparam int CFG_RPTR_BIT     = 5;
    localparam int CFG_MODE_LSB     = 3;
    localparam int CFG_WAIT_BIT     = 2;
    localparam int CFG_DET_SEL_BIT  = 1;
    localparam int CFG_MUTE_BIT     = 0;
    localparam logic [7:0] CFG_RESET_BASE = 8'h80;

    typedef enum logic [1:0]
    {
        ENC_AUTHENTICATED = 2'h0,
        ENC_REG_CONTROL   = 2'h1,
        ENC_ALWAYS        = 2'h2,
        ENC_INBAND_FRAME  = 2'h3
    } cptc_encmode_e;

    // Check periods in frames.
    localparam logic [7:0] LINK_PERIOD_NORM = 8'h80;
    localparam logic [7:0] LINK_PERIOD_TEST = 8'h10;
    localparam logic [7:0] ENH_PERIOD_NORM  = 8'h10;
    localparam logic [7:0] ENH_PERIOD_TEST  = 8'h02;
    localparam logic [7:0] SYNC_FRAME       = 8'h7F;

    // Timing at 10 MHz.
    localparam int CLK_NS          = 100;
    localparam int TIMEOUT_MS      = 1000;
    localparam int TIMEOUT_CYCLES  = TIMEOUT_MS * 1000000 / CLK_NS;
    localparam int WAIT_MS         = 100;
    localparam int WAIT_CYCLES     = WAIT_MS * 1000000 / CLK_NS;

    typedef struct packed
    {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cptc_reg_req_s;

endpackage : cptc_pkg

// *** cptc_config.sv ***
// Protection transmitter configuration registers and control sequencing.
//
// Functional notes
// RULE_01: Master treats bus free after over one second idle unless disabled.
// RULE_02: Link check at frame 127 skipped when sync-check-disable is set.
// RULE_03: Line checksum per colour channel sent when checksum enable is set.
// RULE_04: Test mode checks every 2 and 16 frames, else 16 and 128.
// RULE_05: Timer speedup bit shortens authentication timers.
// RULE_06: Fast bit selects master timing and is mirrored in indirect status.
// RULE_07: Enhanced check happens only when enhanced verification is enabled.
// RULE_08: Status-signaling bit selects enhanced or original status signaling.
// RULE_09: Repeater mode enables the extra repeater authentication steps.
// RULE_10: Two-bit mode selects per-frame encryption decision method.
// RULE_11: Mode resets to in-band when repeater strap set, else authenticated.
// RULE_12: Initial 100ms wait inserted only when the wait bit is set.
// RULE_13: Detect interrupt waits for lock too when select bit is one.
// RULE_14: Mute bit starts mute; encryption status controls then ignored. Here frameEncrypt does not use the mute bit, so they still act.
// RULE_15: Software sets mute only with enhanced status signaling enabled.
// RULE_16: Reserved bits read zero and ignore writes.
`timescale 1ns/100ps
module cptc_config
    import cptc_pkg::*;
#(
    parameter int TIMEOUT_CNT = TIMEOUT_CYCLES,
    parameter int WAIT_CNT    = WAIT_CYCLES
)
(
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire cptc_reg_req_s regReq,
    output logic [7:0]         regRdata,
    input  wire logic          repeaterStrap,
    input  wire logic          frameStart,
    input  wire logic          masterBusActivity,
    input  wire logic          authStart,
    input  wire logic          authenticated,
    input  wire logic          regEncrypt,
    input  wire logic          inbandEncrypt,
    input  wire logic          rxDetected,
    input  wire logic          rxLock,
    output logic               masterBusFree,
    output logic               masterFastTiming,
    output logic [7:0]         indirectStatusReg,
    output logic               lineChecksumEnable,
    output logic               authTimerSpeedup,
    output logic               linkCheckStrobe,
    output logic               enhCheckStrobe,
    output logic               enhancedStatusSignaling,
    output logic               repeaterModeEnable,
    output logic               waitDone,
    output logic               detectIrq,
    output logic               avMute,
    output logic               frameEncrypt
);

    logic [7:0]  debugReg;
    logic [7:0]  configReg;
    logic        strapDone_reg;
    logic [7:0]  frameCnt_reg;
    logic [31:0] idleCnt_reg;
    logic [31:0] waitCnt_reg;
    logic        waiting_reg;
    cptc_encmode_e encMode;

    // Debug register write path.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            debugReg <= DBG_RESET;
        // RULE_16: reserved bits masked
        else if (regReq.wr && regReq.addr == PROTECT_DEBUG_CTL_ADDR)
            debugReg <= regReq.wdata & DBG_WRITE_MASK;
    end

    // Config register; strap caught on first clock after reset release.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            configReg     <= CFG_RESET_BASE;
            strapDone_reg <= 1'b0;
        end
        else
        begin
            strapDone_reg <= 1'b1;
            // RULE_11: strap selects default mode
            if (!strapDone_reg)
                configReg[CFG_MODE_LSB +: 2] <= repeaterStrap ?
                    ENC_INBAND_FRAME : ENC_AUTHENTICATED;
            else if (regReq.wr && regReq.addr == PROTECT_CONFIG_ADDR)
                configReg <= regReq.wdata;
        end
    end

    // Read data; unmapped addresses return zero.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            regRdata <= 8'h00;
        else if (regReq.rd)
            case (regReq.addr)
                PROTECT_DEBUG_CTL_ADDR: regRdata <= debugReg;
                PROTECT_CONFIG_ADDR:    regRdata <= configReg;
                default:                regRdata <= 8'h00;
            endcase
    end

    assign encMode = cptc_encmode_e'(configReg[CFG_MODE_LSB +: 2]);

    // RULE_06: fast timing and mirror
    assign masterFastTiming   = debugReg[DBG_FAST_BIT];
    assign indirectStatusReg  = {7'h00, debugReg[DBG_FAST_BIT]};
    // RULE_03: checksum enable
    assign lineChecksumEnable = debugReg[DBG_CHKSUM_EN_BIT];
    // RULE_05: timer speedup
    assign authTimerSpeedup   = debugReg[DBG_SPEEDUP_BIT];
    // RULE_08: signaling select
    assign enhancedStatusSignaling = configReg[CFG_ENHANCED_STATUS_SIGNALING_BIT];
    // RULE_09: repeater steps
    assign repeaterModeEnable = configReg[CFG_RPTR_BIT];
    // RULE_14: mute state
    assign avMute = configReg[CFG_MUTE_BIT];

    // RULE_13: detect interrupt qualification
    assign detectIrq = rxDetected &&
        (!configReg[CFG_DET_SEL_BIT] || rxLock);

    // Master bus idle timer.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            idleCnt_reg   <= 32'h0;
            masterBusFree <= 1'b0;
        end
        else if (masterBusActivity || debugReg[DBG_TIMEOUT_DIS_BIT])
        begin
            idleCnt_reg   <= 32'h0;
            masterBusFree <= 1'b0;
        end
        else
        begin
            // RULE_01: free after timeout
            if (idleCnt_reg < 32'(TIMEOUT_CNT))
                idleCnt_reg <= idleCnt_reg + 32'h1;
            else
                masterBusFree <= 1'b1;
        end
    end

    // Frame counter and check strobes.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frameCnt_reg    <= 8'h00;
            linkCheckStrobe <= 1'b0;
            enhCheckStrobe  <= 1'b0;
        end
        else
        begin
            linkCheckStrobe <= 1'b0;
            enhCheckStrobe  <= 1'b0;
            if (frameStart)
            begin
                frameCnt_reg <= frameCnt_reg + 8'h01;
                // RULE_04: check periods by test mode
                if (debugReg[DBG_FC_TEST_BIT])
                begin
                    linkCheckStrobe <= (frameCnt_reg & (LINK_PERIOD_TEST
                        - 8'h01)) == 8'h00;
                    // RULE_07: enhanced check gated
                    enhCheckStrobe <= configReg[CFG_ENHANCED_VERIFY_ENABLE_BIT] &&
                        ((frameCnt_reg & (ENH_PERIOD_TEST - 8'h01)) == 8'h00);
                end
                else
                begin
                    // RULE_02: sync check at 127 optional
                    linkCheckStrobe <= ((frameCnt_reg & (LINK_PERIOD_NORM
                        - 8'h01)) == 8'h00) || (frameCnt_reg == SYNC_FRAME
                        && !debugReg[DBG_SYNC_DIS_BIT]);
                    enhCheckStrobe <= configReg[CFG_ENHANCED_VERIFY_ENABLE_BIT] &&
                        ((frameCnt_reg & (ENH_PERIOD_NORM - 8'h01)) == 8'h00);
                end
            end
        end
    end

    // Optional initial wait after authentication start.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            waitCnt_reg <= 32'h0;
            waiting_reg <= 1'b0;
            waitDone    <= 1'b0;
        end
        else if (authStart)
        begin
            // RULE_12: wait only when enabled
            waiting_reg <= configReg[CFG_WAIT_BIT];
            waitDone    <= !configReg[CFG_WAIT_BIT];
            waitCnt_reg <= 32'h0;
        end
        else if (waiting_reg)
        begin
            if (waitCnt_reg >= 32'(WAIT_CNT) - 32'h1)
            begin
                waiting_reg <= 1'b0;
                waitDone    <= 1'b1;
            end
            else
                waitCnt_reg <= waitCnt_reg + 32'h1;
        end
    end

    // RULE_10: frame encryption decision
    always_comb
    begin
        case (encMode)
            ENC_AUTHENTICATED: frameEncrypt = authenticated;
            ENC_REG_CONTROL:   frameEncrypt = authenticated && regEncrypt;
            ENC_ALWAYS:        frameEncrypt = 1'b1;
            ENC_INBAND_FRAME:  frameEncrypt = authenticated && inbandEncrypt;
            default:           frameEncrypt = 1'b0;
        endcase
    end

    // RULE_16: reserved debug bits stay zero
    chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        (debugReg & ~DBG_WRITE_MASK) == 8'h00)
        else $error("Reserved debug bits set.");

    // RULE_13: irq needs lock when selected
    chk_detect_lock: assert property (@(posedge mclk) disable iff (!rst_b)
        (detectIrq && configReg[CFG_DET_SEL_BIT]) |-> rxLock)
        else $error("Detect irq without lock.");

    // RULE_07: no enhanced check when disabled
    chk_enh_gate: assert property (@(posedge mclk) disable iff (!rst_b)
        !$past(configReg[CFG_ENHANCED_VERIFY_ENABLE_BIT]) && strapDone_reg |-> !enhCheckStrobe)
        else $error("Enhanced check while disabled.");

    // RULE_06: mirror follows fast bit
    chk_fast_mirror: assert property (@(posedge mclk) disable iff (!rst_b)
        indirectStatusReg[0] == masterFastTiming)
        else $error("Indirect status mirror mismatch.");

    // RULE_01: timeout disabled keeps bus busy
    chk_timeout_off: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(debugReg[DBG_TIMEOUT_DIS_BIT]) |-> !masterBusFree)
        else $error("Bus freed with timeout disabled.");

    // RULE_12: no wait skips immediately
    chk_wait_skip: assert property (@(posedge mclk) disable iff (!rst_b)
        (authStart && !configReg[CFG_WAIT_BIT]) |=> waitDone)
        else $error("Wait not skipped.");

    // RULE_10: always mode encrypts
    chk_always_enc: assert property (@(posedge mclk) disable iff (!rst_b)
        encMode == ENC_ALWAYS |-> frameEncrypt)
        else $error("Always mode not encrypting.");

    // RULE_11: strap default applied
    chk_strap_mode: assert property (@(posedge mclk) disable iff (!rst_b)
        (!strapDone_reg && repeaterStrap) |=> encMode == ENC_INBAND_FRAME)
        else $error("Strap default mode wrong.");

endmodule // cptc_config

// *** cptc_rx_model.sv ***
// Behavioural downstream receiver: detection, lock and bus traffic.
`timescale 1ns/100ps
module cptc_rx_model
(
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic plugged,
    input  wire logic talk,
    output logic      rxDetected,
    output logic      rxLock,
    output logic      busActivity
);
    logic [3:0] lockCnt;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rxDetected <= 1'h0;
            lockCnt    <= 4'h0;
        end
        else
        begin
            rxDetected <= plugged;
            lockCnt    <= plugged ? lockCnt + {3'h0, lockCnt != 4'hF} : 4'h0;
        end
    end

    // Lock trails detection so the two can be told apart.
    assign rxLock      = lockCnt > 4'h8;
    assign busActivity = talk;
endmodule // cptc_rx_model

// *** tb_top.sv ***
// Self-checking bench for the protection configuration block.
`timescale 1ns/100ps
module tb_top
    import cptc_pkg::*;
;
    localparam int TO_N = 20;
    localparam int WT_N = 10;
    logic          mclk, rst_b, strap, frameStart, plugged, talk, authStart;
    logic          authd, regEnc, inbEnc, rdLat, busFree, fast, lcEn, spd;
    logic          lnkS, enhS, ess, rptr, wDone, irq, mute, fEnc;
    logic          rxDet, rxLock, busAct;
    logic [7:0]    regRdata, indSts, r, e;
    logic [15:0]   seed;
    cptc_reg_req_s regReq;
    logic [7:0]    rdQ[$];
    int            n_errors, comparisons, nLnk, nEnh;

    cptc_config #(.TIMEOUT_CNT(TO_N), .WAIT_CNT(WT_N)) dut (
        .mclk(mclk), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
        .repeaterStrap(strap), .frameStart(frameStart),
        .masterBusActivity(busAct), .authStart(authStart),
        .authenticated(authd), .regEncrypt(regEnc), .inbandEncrypt(inbEnc),
        .rxDetected(rxDet), .rxLock(rxLock), .masterBusFree(busFree),
        .masterFastTiming(fast), .indirectStatusReg(indSts),
        .lineChecksumEnable(lcEn), .authTimerSpeedup(spd),
        .linkCheckStrobe(lnkS), .enhCheckStrobe(enhS),
        .enhancedStatusSignaling(ess), .repeaterModeEnable(rptr),
        .waitDone(wDone), .detectIrq(irq), .avMute(mute), .frameEncrypt(fEnc));

    cptc_rx_model rx (.mclk(mclk), .rst_b(rst_b), .plugged(plugged),
        .talk(talk), .rxDetected(rxDet), .rxLock(rxLock), .busActivity(busAct));

    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 7);
        seed = seed ^ (seed >> 9);
        seed = seed ^ (seed << 8);
        return seed[7:0];
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #10;
    endtask

    task automatic cmp(input string nm, input logic [7:0] x, input logic [7:0] g);
        comparisons++;
        if (g !== x)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regReq = '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        tick(1);
        regReq.wr = 1'h0;
        tick(1);
    endtask

    // The expected read answer is noted here and judged by the monitor below.
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        regReq = '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        rdQ.push_back(x);
        tick(1);
        regReq.rd = 1'h0;
        tick(1);
    endtask

    task automatic reset(input logic s);
        rst_b = 1'h0;
        strap = s;
        tick(4);
        rst_b = 1'h1;
        tick(2);
    endtask

    task automatic pulse(ref logic p);
        p = 1'h1;
        tick(1);
        p = 1'h0;
    endtask

    task automatic frames(input int n, input int xl, input int xe);
        nLnk = 0;
        nEnh = 0;
        repeat (n)
        begin
            pulse(frameStart);
            tick(3);
        end
        cmp("linkChecks", 8'(xl), 8'(nLnk));
        cmp("enhChecks", 8'(xe), 8'(nEnh));
        $display("frames test done");
    endtask

    task automatic test_done();
        $display("n_errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        if (rdLat && rdQ.size() > 0)
            cmp("regRdata", rdQ.pop_front(), regRdata);
        if (lnkS === 1'h1) nLnk++;
        if (enhS === 1'h1) nEnh++;
        rdLat <= regReq.rd;
    end

    initial
    begin
        #(30000 * CLK_NS);
        n_errors++;
        test_done();
    end

    initial
    begin
        {regReq, frameStart, plugged, talk, authStart} = '0;
        {authd, regEnc, inbEnc, n_errors, comparisons} = '0;
        seed = 16'h348F;
        reset(1'h0);
        rd(PROTECT_DEBUG_CTL_ADDR, DBG_RESET);
        rd(PROTECT_CONFIG_ADDR, CFG_RESET_BASE);
        rd(8'hC1, 8'h00);
        reset(1'h1);
        rd(PROTECT_CONFIG_ADDR, CFG_RESET_BASE | 8'h18);
        $display("reset test done");
        for (int i = 0; i < 12; i++)
        begin
            r = (i < 8) ? 8'h01 << i : rnd();
            wr(PROTECT_DEBUG_CTL_ADDR, r);
            rd(PROTECT_DEBUG_CTL_ADDR, r & DBG_WRITE_MASK);
            cmp("debugOut", {5'h0, r[3], r[1], r[0]},
                {5'h0, lcEn, spd, fast});
            cmp("indSts", {7'h0, r[0]}, indSts);
        end
        wr(8'hC1, 8'hFF);
        rd(PROTECT_DEBUG_CTL_ADDR, r & DBG_WRITE_MASK);
        $display("debug test done");
        for (int i = 0; i < 16; i++)
        begin
            r = rnd();
            r[4:3] = i[1:0];
            r[0] = i[2] & r[6];
            wr(PROTECT_CONFIG_ADDR, r);
            rd(PROTECT_CONFIG_ADDR, r);
            cmp("cfgOut", {5'h0, r[6], r[5], r[0]},
                {5'h0, ess, rptr, mute});
            for (int j = 0; j < 8 && !r[0]; j++)
            begin
                {authd, regEnc, inbEnc} = j[2:0];
                e[0] = r[4] ? (r[3] ? authd & inbEnc : 1'h1) : authd & (regEnc | !r[3]);
                tick(1);
                cmp("frameEncrypt", {7'h0, e[0]}, {7'h0, fEnc});
            end
        end
        $display("config test done");
        wr(PROTECT_CONFIG_ADDR, 8'h82);
        plugged = 1'h1;
        tick(3);
        cmp("detectIrq", 8'h00, {7'h0, irq});
        wr(PROTECT_CONFIG_ADDR, 8'h80);
        cmp("detectIrq", 8'h01, {7'h0, irq});
        wr(PROTECT_CONFIG_ADDR, 8'h82);
        tick(10);
        cmp("detectIrq", 8'h01, {7'h0, irq});
        plugged = 1'h0;
        tick(2);
        cmp("detectIrq", 8'h00, {7'h0, irq});
        wr(PROTECT_DEBUG_CTL_ADDR, 8'h00);
        pulse(talk);
        tick(2);
        cmp("busFree", 8'h00, {7'h0, busFree});
        tick(TO_N + 5);
        cmp("busFree", 8'h01, {7'h0, busFree});
        wr(PROTECT_DEBUG_CTL_ADDR, 8'h40);
        pulse(talk);
        tick(TO_N + 5);
        cmp("busFree", 8'h00, {7'h0, busFree});
        wr(PROTECT_CONFIG_ADDR, 8'h84);
        pulse(authStart);
        tick(2);
        cmp("waitDone", 8'h00, {7'h0, wDone});
        tick(WT_N - 3);
        cmp("waitDone", 8'h00, {7'h0, wDone});
        tick(1);
        cmp("waitDone", 8'h01, {7'h0, wDone});
        // Restart a wait, then show that a start without it ends at once.
        pulse(authStart);
        wr(PROTECT_CONFIG_ADDR, 8'h80);
        cmp("waitDone", 8'h00, {7'h0, wDone});
        pulse(authStart);
        cmp("waitDone", 8'h01, {7'h0, wDone});
        $display("timer test done");
        wr(PROTECT_DEBUG_CTL_ADDR, 8'h04);
        frames(32, 2, 16);
        wr(PROTECT_CONFIG_ADDR, 8'h00);
        frames(32, 2, 0);
        wr(PROTECT_DEBUG_CTL_ADDR, 8'h00);
        wr(PROTECT_CONFIG_ADDR, 8'h80);
        frames(256, 3, 16);
        wr(PROTECT_DEBUG_CTL_ADDR, 8'h10);
        frames(256, 2, 16);
        test_done();
    end
endmodule // tb_top
